// >>> shared/can_brtp_pkg.sv
// constants for the bit-rate and transmit-priority block
package can_brtp_pkg;
  localparam int NBUF       = 4;
  localparam int IDW        = 11;
  localparam int FIFO_DEPTH = 4;
  // register byte addresses
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_TXREQ  = 8'h08;
  localparam logic [7:0] ADDR_FIFO   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [3:0] ADDR_TXID_HI = 4'h2;
  // config register fields
  localparam int CFG_PRESC_LSB = 0;
  localparam int PRESC_W       = 10;
  localparam int CFG_CLKSRC    = 10;
  localparam int CFG_PRIO      = 11;
  localparam int CFG_RUN       = 12;
  localparam int CFG_FIFO_EN   = 13;
  localparam int CFG_LINK_LSB  = 14;
  // timing register fields
  localparam int TIM_T1_LSB  = 0;
  localparam int TIM_T2_LSB  = 8;
  localparam int TIM_SJW_LSB = 16;
  // status register fields
  localparam int ST_SEND_BIT  = 0;
  localparam int ST_SRC_LSB   = 1;
  localparam int ST_ID_LSB    = 4;
  localparam int ST_CNT_LSB   = 16;
  localparam int ST_FULL_BIT  = 19;
  localparam int ST_SAMPLE    = 20;
  // reset values
  localparam logic [9:0] PRESC_RST = 10'h000;
  localparam logic [4:0] TSEG1_RST = 5'h04;
  localparam logic [3:0] TSEG2_RST = 4'h3;
  localparam logic [2:0] SJW_RST   = 3'h1;
  // priority methods and sources
  localparam logic       PRIO_ID  = 1'b0;
  localparam logic       PRIO_BUF = 1'b1;
  localparam logic       SRC_SYS2 = 1'b0;
  localparam logic [2:0] SRC_FIFO = 3'h4;
  typedef enum {ST_IDLE, ST_SEND} tx_state_e;
endpackage : can_brtp_pkg

// >>> verilog/can_bit_rate_tx_priority.sv
// bit-rate generation and transmit-priority selection
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module can_bit_rate_tx_priority
  import can_brtp_pkg::*;
(
  // clock and reset
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  // register port
  input  wire logic [7:0]     addr_in,
  input  wire logic [31:0]    wdata_in,
  input  wire logic           wr_in,
  input  wire logic           rd_in,
  output logic      [31:0]    rdata_out,
  // kernel clock source and bus
  input  wire logic           xtal_tick_in,
  input  wire logic           can_rx_in,
  output logic                tq_tick_out,
  output logic                bit_tick_out,
  output logic                sample_out,
  // transmit engine
  input  wire logic           tx_start_in,
  input  wire logic           tx_done_in,
  input  wire logic           tx_retry_in,
  output logic                sending_out,
  output logic      [2:0]     sel_src_out,
  output logic      [IDW-1:0] sel_id_out
);

  logic [PRESC_W-1:0] presc_r;
  logic               clk_src_r;
  logic               prio_r;
  logic               run_r;
  logic               fifo_en_r;
  logic [1:0]         link_r;
  logic [4:0]         tseg1_r;
  logic [3:0]         tseg2_r;
  logic [2:0]         sjw_r;
  logic               div_r;
  logic [PRESC_W-1:0] presc_cnt_r;
  logic [5:0]         tq_idx_r;
  logic               tq_tick_r;
  logic               bit_tick_r;
  logic               sample_r;
  logic               samp_stb_r;
  logic [31:0]        rdata_r;
  logic [NBUF-1:0]    req_r;
  logic [IDW-1:0]     txid_r [NBUF];
  logic [IDW-1:0]     fifo_mem_r [FIFO_DEPTH];
  logic [2:0]         wr_ptr_r;
  logic [2:0]         rd_ptr_r;
  tx_state_e          st_r;
  logic [2:0]         sel_src_r;
  logic [IDW-1:0]     sel_id_r;
  logic [PRESC_W:0]   kt_seen_r;
  logic               sending_r;
  logic               kern_tick;
  logic               tq_en;
  logic [5:0]         bit_last;
  logic               cfg_wr;
  logic               txid_sel;
  logic [2:0]         fifo_cnt;
  logic               fifo_full;
  logic [2:0]         fifo_off;
  logic [1:0]         fifo_idx;
  logic               fifo_cand_v;
  logic [IDW-1:0]     fifo_cand_id;
  logic               best_v;
  logic [2:0]         best_src;
  logic [IDW-1:0]     best_id;
  logic               pick;
  logic [NBUF-1:0]    req_set;
  logic [NBUF-1:0]    req_clr;
  logic               id_viol;

  assign cfg_wr   = wr_in && (addr_in == ADDR_CFG);
  assign txid_sel = (addr_in[7:4] == ADDR_TXID_HI) && (addr_in[1:0] == 2'h0);

  // configuration; timing and prescaler frozen while running
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_r   <= PRESC_RST;
      clk_src_r <= SRC_SYS2;
      prio_r    <= PRIO_ID;
      run_r     <= 1'b0;
      fifo_en_r <= 1'b0;
      link_r    <= 2'h0;
      tseg1_r   <= TSEG1_RST;
      tseg2_r   <= TSEG2_RST;
      sjw_r     <= SJW_RST;
    end else begin
      if (cfg_wr) begin
        run_r     <= wdata_in[CFG_RUN];
        fifo_en_r <= wdata_in[CFG_FIFO_EN];
        link_r    <= wdata_in[CFG_LINK_LSB +: 2];
        prio_r    <= wdata_in[CFG_PRIO];
        if (!run_r) begin
          presc_r   <= wdata_in[CFG_PRESC_LSB +: PRESC_W];
          clk_src_r <= wdata_in[CFG_CLKSRC];
        end
      end
      if (wr_in && addr_in == ADDR_TIMING && !run_r) begin
        tseg1_r <= wdata_in[TIM_T1_LSB +: 5];
        tseg2_r <= wdata_in[TIM_T2_LSB +: 4];
        sjw_r   <= wdata_in[TIM_SJW_LSB +: 3];
      end
    end
  end

  // kernel clock enable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end

  assign kern_tick = (clk_src_r == SRC_SYS2) ? div_r : xtal_tick_in;
  assign tq_en     = run_r && kern_tick && (presc_cnt_r == presc_r);
  assign bit_last  = {1'b0, tseg1_r} + {2'h0, tseg2_r};
  // quantum prescaler
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_cnt_r <= '0;
      tq_tick_r   <= 1'b0;
    end else begin
      tq_tick_r <= tq_en;
      if (!run_r || tq_en) begin
        presc_cnt_r <= '0;
      end else if (kern_tick) begin
        presc_cnt_r <= presc_cnt_r + 10'h001;
      end
    end
  end

  // quanta within a bit and sample point
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tq_idx_r   <= '0;
      bit_tick_r <= 1'b0;
      sample_r   <= 1'b1;
      samp_stb_r <= 1'b0;
    end else begin
      bit_tick_r <= tq_en && (tq_idx_r == bit_last);
      samp_stb_r <= tq_en && (tq_idx_r == {1'b0, tseg1_r});
      if (!run_r) begin
        tq_idx_r <= '0;
      end else if (tq_en) begin
        tq_idx_r <= (tq_idx_r == bit_last) ? 6'h00 : tq_idx_r + 6'h01;
      end
      if (tq_en && tq_idx_r == {1'b0, tseg1_r}) begin
        sample_r <= can_rx_in;
      end
    end
  end
  // transmit buffer identifiers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int b = 0; b < NBUF; b++) begin
        txid_r[b] <= '0;
      end
    end else if (wr_in && txid_sel) begin
      txid_r[addr_in[3:2]] <= wdata_in[IDW-1:0];
    end
  end

  // requests: a new request wins over a completion clear
  assign req_set = (wr_in && addr_in == ADDR_TXREQ) ? wdata_in[NBUF-1:0] : '0;
  assign req_clr = (st_r == ST_SEND && tx_done_in && sel_src_r != SRC_FIFO) ?
                   (4'h1 << sel_src_r[1:0]) : '0;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_r <= '0;
    end else begin
      req_r <= (req_r & ~req_clr) | req_set;
    end
  end

  // transmit-mode FIFO, oldest at the read pointer
  assign fifo_cnt  = wr_ptr_r - rd_ptr_r;
  assign fifo_full = (fifo_cnt == 3'(FIFO_DEPTH));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      for (int e = 0; e < FIFO_DEPTH; e++) begin
        fifo_mem_r[e] <= '0;
      end
    end else begin
      if (wr_in && addr_in == ADDR_FIFO && !fifo_full) begin
        fifo_mem_r[wr_ptr_r[1:0]] <= wdata_in[IDW-1:0];
        wr_ptr_r                  <= wr_ptr_r + 3'h1;
      end
      if (st_r == ST_SEND && tx_done_in && sel_src_r == SRC_FIFO) begin
        rd_ptr_r <= rd_ptr_r + 3'h1;
      end
    end
  end
  // candidate of the FIFO: next entry while its head is on the bus
  assign fifo_off     = (st_r == ST_SEND && sel_src_r == SRC_FIFO) ? 3'h1 : 3'h0;
  assign fifo_idx     = rd_ptr_r[1:0] + fifo_off[1:0];
  assign fifo_cand_v  = fifo_en_r && (fifo_cnt > fifo_off);
  assign fifo_cand_id = fifo_mem_r[fifo_idx];
  // priority selection
  always_comb begin
    best_v   = 1'b0;
    best_src = 3'h0;
    best_id  = '0;
    for (int b = 0; b < NBUF; b++) begin
      if (req_r[b] && (!best_v || (prio_r == PRIO_ID && txid_r[b] < best_id))) begin
        best_v   = 1'b1;
        best_src = 3'(b);
        best_id  = txid_r[b];
      end
    end
    if (fifo_cand_v) begin
      if (!best_v ||
          (prio_r == PRIO_ID && fifo_cand_id < best_id) ||
          (prio_r == PRIO_BUF && {1'b0, link_r} < best_src)) begin
        best_v   = 1'b1;
        best_src = SRC_FIFO;
        best_id  = fifo_cand_id;
      end
    end
  end
  assign pick = (st_r == ST_IDLE) && tx_start_in && best_v;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r      <= ST_IDLE;
      sel_src_r <= '0;
      sel_id_r  <= '0;
      sending_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (pick) begin
            st_r      <= ST_SEND;
            sel_src_r <= best_src;
            sel_id_r  <= best_id;
            sending_r <= 1'b1;
          end
        end
        ST_SEND: begin
          if (tx_done_in || tx_retry_in) begin
            st_r      <= ST_IDLE;
            sending_r <= 1'b0;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
  // register read port
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (rd_in) begin
        if (addr_in == ADDR_CFG) begin
          rdata_r[CFG_PRESC_LSB +: PRESC_W] <= presc_r;
          rdata_r[CFG_CLKSRC]               <= clk_src_r;
          rdata_r[CFG_PRIO]                 <= prio_r;
          rdata_r[CFG_RUN]                  <= run_r;
          rdata_r[CFG_FIFO_EN]              <= fifo_en_r;
          rdata_r[CFG_LINK_LSB +: 2]        <= link_r;
        end else if (addr_in == ADDR_TIMING) begin
          rdata_r[TIM_T1_LSB +: 5]  <= tseg1_r;
          rdata_r[TIM_T2_LSB +: 4]  <= tseg2_r;
          rdata_r[TIM_SJW_LSB +: 3] <= sjw_r;
        end else if (addr_in == ADDR_TXREQ) begin
          rdata_r[NBUF-1:0] <= req_r;
        end else if (addr_in == ADDR_STATUS) begin
          rdata_r[ST_SEND_BIT]          <= (st_r == ST_SEND);
          rdata_r[ST_SRC_LSB +: 3]      <= sel_src_r;
          rdata_r[ST_ID_LSB +: IDW]     <= sel_id_r;
          rdata_r[ST_CNT_LSB +: 3]      <= fifo_cnt;
          rdata_r[ST_FULL_BIT]          <= fifo_full;
          rdata_r[ST_SAMPLE]            <= sample_r;
        end else if (txid_sel) begin
          rdata_r[IDW-1:0] <= txid_r[addr_in[3:2]];
        end
      end
    end
  end

  assign rdata_out    = rdata_r;
  assign tq_tick_out  = tq_tick_r;
  assign bit_tick_out = bit_tick_r;
  assign sample_out   = sample_r;
  assign sending_out  = sending_r;
  assign sel_src_out  = sel_src_r;
  assign sel_id_out   = sel_id_r;
  // checking helpers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kt_seen_r <= '0;
    end else if (!run_r || tq_en) begin
      kt_seen_r <= '0;
    end else if (kern_tick) begin
      kt_seen_r <= kt_seen_r + 11'h001;
    end
  end

  always_comb begin
    id_viol = 1'b0;
    for (int b = 0; b < NBUF; b++) begin
      if (req_r[b] && (txid_r[b] < best_id ||
          (txid_r[b] == best_id && best_src != SRC_FIFO && 3'(b) < best_src))) begin
        id_viol = 1'b1;
      end
    end
    if (fifo_cand_v && fifo_cand_id < best_id) begin
      id_viol = 1'b1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_quantum_length: assert property (tq_en |-> kt_seen_r == {1'b0, presc_r})
    else $error("quantum not prescaler plus one kernel ticks");
  a_div2_alternate: assert property ((clk_src_r == SRC_SYS2) && kern_tick
      |=> !kern_tick || clk_src_r != SRC_SYS2)
    else $error("halved system clock ticked twice in a row");
  a_bit_wrap: assert property (tq_en && tq_idx_r == bit_last |=> bit_tick_r && tq_idx_r == 6'h00)
    else $error("bit did not end after last quantum");
  a_sample_point: assert property (samp_stb_r |-> $past(tq_idx_r) == {1'b0, $past(tseg1_r)})
    else $error("sample taken off the segment boundary");
  a_id_winner: assert property (pick && prio_r == PRIO_ID |-> !id_viol)
    else $error("ID priority picked a losing candidate");
  a_buf_lowest: assert property (pick && prio_r == PRIO_BUF && best_src != SRC_FIFO
      |=> ($past(req_r) & ((4'h1 << sel_src_r[1:0]) - 4'h1)) == 4'h0)
    else $error("buffer priority skipped a lower pending buffer");
  a_fifo_rank: assert property (pick && prio_r == PRIO_BUF && best_src == SRC_FIFO
      |-> (req_r & ((4'h2 << link_r) - 4'h1)) == 4'h0)
    else $error("FIFO beat a buffer at or below its link");
  a_fifo_oldest: assert property (pick && best_src == SRC_FIFO
      |=> sel_id_r == $past(fifo_mem_r[rd_ptr_r[1:0]]))
    else $error("FIFO offered other than its oldest entry");
  a_fifo_next: assert property (st_r == ST_SEND && sel_src_r == SRC_FIFO
      |-> fifo_idx == rd_ptr_r[1:0] + 2'h1)
    else $error("FIFO candidate not the next queued entry");
  a_retry_rerun: assert property (st_r == ST_SEND && tx_retry_in |=> st_r == ST_IDLE)
    else $error("retry did not reopen selection");

endmodule : can_bit_rate_tx_priority

// >>> sim/can_bus_node.sv
// far-side model: other bus nodes plus the external crystal tick
`timescale 1ns/1ps
module can_bus_node (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // bus view
  input  wire logic bit_tick_in,
  input  wire logic drive_dom_in,
  output logic      can_rx_out,
  output logic      xtal_tick_out
);
  logic [1:0] div_r;

  // crystal tick every third clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r         <= 2'h0;
      xtal_tick_out <= 1'b0;
    end else begin
      div_r         <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      xtal_tick_out <= (div_r == 2'h2);
    end
  end

  // level changes only at bit boundaries; released bus floats recessive
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      can_rx_out <= 1'b1;
    end else if (bit_tick_in) begin
      can_rx_out <= !drive_dom_in;
    end
  end
endmodule : can_bus_node

// >>> sim/testbench.sv
// register-level tests of bit timing and transmit selection
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  import can_brtp_pkg::*;
  logic           clk_in = 1'b0;
  logic           rst_n_in = 1'b0;
  logic [7:0]     addr_in = 8'h00;
  logic [31:0]    wdata_in = 32'h0;
  logic           wr_in = 1'b0;
  logic           rd_in = 1'b0;
  logic [31:0]    rdata_out;
  logic           xtal_tick_in;
  logic           can_rx_in;
  logic           tq_tick_out;
  logic           bit_tick_out;
  logic           sample_out;
  logic           tx_start_in = 1'b0;
  logic           tx_done_in = 1'b0;
  logic           tx_retry_in = 1'b0;
  logic           sending_out;
  logic [2:0]     sel_src_out;
  logic [IDW-1:0] sel_id_out;
  logic           dom = 1'b0;
  int             miscompares = 0;
  int             checks_done = 0;

  always #5 clk_in = ~clk_in;

  can_bit_rate_tx_priority dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .xtal_tick_in(xtal_tick_in), .can_rx_in(can_rx_in), .tq_tick_out(tq_tick_out),
    .bit_tick_out(bit_tick_out), .sample_out(sample_out), .tx_start_in(tx_start_in),
    .tx_done_in(tx_done_in), .tx_retry_in(tx_retry_in), .sending_out(sending_out),
    .sel_src_out(sel_src_out), .sel_id_out(sel_id_out));

  can_bus_node node (.clk_in(clk_in), .rst_n_in(rst_n_in), .bit_tick_in(bit_tick_out),
    .drive_dom_in(dom), .can_rx_out(can_rx_in), .xtal_tick_out(xtal_tick_in));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out, e)
  endtask : rd

  // start, done, retry as one-cycle pulses
  task automatic kick(input logic [2:0] w);
    @(posedge clk_in);
    {tx_start_in, tx_done_in, tx_retry_in} <= w;
    @(posedge clk_in);
    {tx_start_in, tx_done_in, tx_retry_in} <= 3'b000;
    #1;
  endtask : kick

  task automatic sel(input logic [2:0] s, input logic [10:0] id);
    kick(3'b100);
    `CHK({sending_out, sel_src_out, sel_id_out}, {1'b1, s, id})
  endtask : sel

  task automatic fin(input logic [2:0] w);
    kick(w);
    `CHK(sending_out, 1'b0)
  endtask : fin

  // clocks between two pulses of bit tick (b=1) or quantum tick (b=0)
  task automatic gap(input bit b, input int e);
    int n;
    n = 0;
    do @(posedge clk_in); while ((b ? bit_tick_out : tq_tick_out) !== 1'b1);
    do begin
      @(posedge clk_in);
      n++;
    end while ((b ? bit_tick_out : tq_tick_out) !== 1'b1 && n < 2000);
    `CHK(n, e)
  endtask : gap

  task automatic wrap_up;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(ADDR_CFG, 32'h0000_0000);
    rd(ADDR_TIMING, 32'h0001_0304);
    rd(ADDR_STATUS, 32'h0010_0000);
    rd(8'h40, 32'h0000_0000);
    $display("test reset done");

    wr(ADDR_CFG, 32'h0000_0001);
    wr(ADDR_TIMING, 32'h0001_0304);
    wr(ADDR_CFG, 32'h0000_1001);
    gap(1'b1, 32);
    gap(1'b0, 4);
    wr(ADDR_CFG, 32'h0000_1005);
    rd(ADDR_CFG, 32'h0000_1001);
    wr(ADDR_CFG, 32'h0000_0000);
    wr(ADDR_CFG, 32'h0000_0400);
    wr(ADDR_TIMING, 32'h0001_0205);
    wr(ADDR_CFG, 32'h0000_1400);
    gap(1'b1, 24);
    dom <= 1'b1;
    gap(1'b1, 24);
    gap(1'b1, 24);
    `CHK(sample_out, 1'b0)
    dom <= 1'b0;
    gap(1'b1, 24);
    gap(1'b1, 24);
    `CHK(sample_out, 1'b1)
    wr(ADDR_CFG, 32'h0000_0000);
    $display("test timing done");

    wr(8'h20, 32'h300);
    wr(8'h24, 32'h100);
    wr(8'h28, 32'h100);
    wr(8'h2C, 32'h200);
    wr(ADDR_CFG, 32'h0000_2000);
    wr(ADDR_TXREQ, 32'h6);
    sel(3'h1, 11'h100);
    fin(3'b010);
    sel(3'h2, 11'h100);
    fin(3'b010);
    wr(ADDR_FIFO, 32'h050);
    wr(ADDR_FIFO, 32'h400);
    wr(ADDR_TXREQ, 32'h9);
    sel(SRC_FIFO, 11'h050);
    fin(3'b010);
    sel(3'h3, 11'h200);
    fin(3'b010);
    sel(3'h0, 11'h300);
    fin(3'b010);
    sel(SRC_FIFO, 11'h400);
    fin(3'b010);
    kick(3'b100);
    `CHK(sending_out, 1'b0)
    $display("test id priority done");

    wr(8'h2C, 32'h010);
    wr(ADDR_CFG, 32'h0000_6800);
    wr(ADDR_FIFO, 32'h001);
    wr(ADDR_TXREQ, 32'hC);
    sel(SRC_FIFO, 11'h001);
    fin(3'b010);
    sel(3'h2, 11'h100);
    wr(ADDR_TXREQ, 32'h1);
    fin(3'b001);
    sel(3'h0, 11'h300);
    fin(3'b010);
    sel(3'h2, 11'h100);
    fin(3'b010);
    sel(3'h3, 11'h010);
    fin(3'b010);
    rd(ADDR_TXREQ, 32'h0000_0000);
    $display("test buffer priority done");
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_FIFO, 32'h7F0 + i);
    end
    rd(ADDR_STATUS, 32'h001C_0106);
    $display("test fifo full done");
    wrap_up;
  end
endmodule : testbench
